// ### scs_card_model.sv
// Behavioural card answering each activation of the supply
module scs_card_model
    import scs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        vcc_on,
    input  wire logic [1:0]  mode,
    input  wire logic [4:0]  flags,
    input  wire logic [7:0]  delay,
    output logic             answered,
    output logic [31:0]      word
);
    logic [7:0]  age_r;
    logic [31:0] ans;

    // Age restarts at every activation
    always_ff @(posedge aclk)
    begin
        if (!vcc_on)
        begin
            age_r <= 8'h0;
        end
        else if (age_r != 8'hff)
        begin
            age_r <= age_r + 8'h1;
        end
    end

    // Outcome in bits 9:8, class flags A..E in bits 4:0; gapped sets only on demand
    assign ans      = {22'h0, mode, 3'h0, flags};
    assign answered = vcc_on && (age_r >= delay);
    // No answer on the line: show the inverse
    assign word     = answered ? ans : ~ans;
endmodule

// ### scs_log_mem.sv
// Small log memory of answer outcomes, registered read data
module scs_log_mem
    import scs_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  we,
    input  wire logic [SCS_LOG_AW-1:0] waddr,
    input  wire logic [15:0]           wdata,
    input  wire logic [SCS_LOG_AW-1:0] raddr,
    output logic      [15:0]           rdata
);
    logic [15:0] mem [0:(1<<SCS_LOG_AW)-1];

    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        rdata <= mem[raddr];
    end
endmodule

// ### scs_pkg.sv
// Package with register map, field layouts and states for the supply class sequencer
package scs_pkg;

    // Register byte offsets
    localparam logic [7:0] SCS_CTRL_OFF   = 8'h00;
    localparam logic [7:0] SCS_CAPS_OFF   = 8'h04;
    localparam logic [7:0] SCS_ATR_OFF    = 8'h08;
    localparam logic [7:0] SCS_STAT_OFF   = 8'h0c;
    localparam logic [7:0] SCS_IRQ_OFF    = 8'h10;
    localparam logic [7:0] SCS_MASK_OFF   = 8'h14;
    localparam logic [7:0] SCS_APP_OFF    = 8'h18;
    localparam logic [7:0] SCS_BUDGET_OFF = 8'h1c;
    localparam logic [7:0] SCS_ATRLOG_OFF = 8'h20;

    // Class flag layout: bit 0 A (lowest class letter) up to bit 4 E
    localparam int         SCS_NCLASS     = 5;
    localparam logic [4:0] SCS_CAPS_RST   = 5'h07;

    // Control register bits
    localparam int CTRL_START = 0;
    localparam int CTRL_CORR_RETRY = 1;
    localparam int CTRL_DEACT_REJ = 2;

    // Event bits (irq status / mask)
    localparam int EV_ACT     = 0;
    localparam int EV_READY   = 1;
    localparam int EV_REJECT  = 2;
    localparam int EV_DESEL   = 3;
    localparam int EV_BADSET  = 4;
    localparam int SCS_NEV    = 5;

    // Number of corrupted answers in one class that triggers moving or rejecting
    localparam logic [1:0] SCS_CORR_MAX = 2'h3;

    // Budget defaults, milliamps
    localparam logic [7:0] SCS_MIN_BUDGET = 8'h0a;
    localparam logic [7:0] SCS_USB_BUDGET = 8'h3c;

    // Answer outcome codes
    localparam logic [1:0] ATR_NONE    = 2'h0;
    localparam logic [1:0] ATR_VALID   = 2'h1;
    localparam logic [1:0] ATR_CORRUPT = 2'h2;

    // Log memory address width (16 entries)
    localparam int SCS_LOG_AW = 4;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_ACTIVE = 6'b000010,
        ST_WAIT   = 6'b000100,
        ST_DEACT  = 6'b001000,
        ST_READY  = 6'b010000,
        ST_REJECT = 6'b100000
    } scs_state_t;

endpackage

// ### scs_seq.sv
// Supply voltage class selection sequencer with AXI4-Lite registers
// Overview of operation
// - Class flags: A bit 0, B bit 1, C bit 2, D bit 3, E bit 4.
// - Several flags must be consecutive; a gap is illegal.
// - Application selected after access check, or after an application command.
// - Select plus status query alone is not an application command.
module scs_seq
    import scs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [4:0]       vcc_class,
    output logic             vcc_on,
    output logic             apdu_allowed,
    output logic             irq
);
    import scs_pkg::*;

    // ==========================================================
    // Register bus
    // ==========================================================
    logic        aw_hold_r;
    logic [7:0]  aw_addr_r;
    logic        w_hold_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;

    logic [2:0]  ctrl_r;
    logic [4:0]  caps_r;
    logic [7:0]  atr_r;
    logic [SCS_NEV-1:0] ists_r;
    logic [SCS_NEV-1:0] imask_r;
    logic [SCS_NEV-1:0] ev;
    logic [7:0]  app_need_r;
    logic [7:0]  cap_lim_r;
    logic [3:0]  app_flags_r;
    logic        usb_on_r;
    logic        start_p;
    logic        atr_p;
    logic [1:0]  atr_kind;
    logic [4:0]  atr_cls;
    logic [SCS_LOG_AW-1:0] log_raddr_r;
    logic [15:0] log_rdata;

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (wr_go)
            begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (wr_go)
            begin
                w_hold_r <= 1'b0;
            end
        end
    end

    always_comb
    begin
        wr_ok = 1'b1;
        if (aw_addr_r[1:0] != 2'h0) wr_ok = 1'b0;
        else if (aw_addr_r > SCS_BUDGET_OFF && aw_addr_r != SCS_ATRLOG_OFF) wr_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h3;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Writable fields; every write is gated by the low byte lane strobe alone, though fields reach up to bit 11
    logic wr_lo;
    assign wr_lo   = wr_go && w_strb_r[0];
    assign start_p = wr_lo && aw_addr_r == SCS_CTRL_OFF && w_data_r[CTRL_START];
    assign atr_p   = wr_lo && aw_addr_r == SCS_ATR_OFF;
    assign atr_kind = w_data_r[9:8];
    assign atr_cls  = w_data_r[4:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r      <= 3'h0;
            caps_r      <= SCS_CAPS_RST;
            imask_r     <= '0;
            cap_lim_r   <= SCS_MIN_BUDGET;
            app_need_r  <= 8'h00;
            app_flags_r <= 4'h0;
            usb_on_r    <= 1'b0;
            log_raddr_r <= '0;
        end
        else if (wr_lo)
        begin
            if (aw_addr_r == SCS_CTRL_OFF)
                ctrl_r <= {w_data_r[CTRL_DEACT_REJ], w_data_r[CTRL_CORR_RETRY], 1'b0};
            else if (aw_addr_r == SCS_CAPS_OFF)
                caps_r <= w_data_r[4:0];
            else if (aw_addr_r == SCS_MASK_OFF)
                imask_r <= w_data_r[SCS_NEV-1:0];
            else if (aw_addr_r == SCS_APP_OFF)
            begin
                // [7:0] need, [11:8] flags: present, access ok, app cmd, status only
                app_need_r  <= w_data_r[7:0];
                app_flags_r <= w_data_r[11:8];
            end
            else if (aw_addr_r == SCS_BUDGET_OFF)
            begin
                cap_lim_r <= w_data_r[7:0];
                usb_on_r  <= w_data_r[8];
            end
            else if (aw_addr_r == SCS_ATRLOG_OFF)
                log_raddr_r <= w_data_r[SCS_LOG_AW-1:0];
        end
    end

    // ==========================================================
    // Class sequencer
    // ==========================================================
    scs_state_t  state_r;
    logic [4:0]  cls_r;
    logic [1:0]  corr_cnt_r;
    logic [4:0]  card_cls_r;
    logic        first_r;
    logic [4:0]  lowest;
    logic [4:0]  next_up;
    logic [4:0]  common;
    logic [4:0]  common_low;
    logic        consec;

    // Lowest voltage is the highest class letter; one-hot pick of caps
    always_comb
    begin
        lowest = 5'h00;
        for (int i = 0; i < SCS_NCLASS; i++)
            if (caps_r[i]) lowest = 5'(1 << i);
    end

    // Next higher voltage is the neighbouring lower bit only
    assign next_up    = (cls_r >> 1) & caps_r;
    assign common     = atr_cls & caps_r;
    // Lowest voltage among the common set
    always_comb
    begin
        common_low = 5'h00;
        for (int i = 0; i < SCS_NCLASS; i++)
            if (common[i]) common_low = 5'(1 << i);
    end

    // Set bits must be one consecutive run
    logic [4:0] run_t;
    assign run_t  = atr_cls + (atr_cls & (~atr_cls + 5'h01));
    assign consec = (atr_cls != 5'h00) && ((run_t & atr_cls) == 5'h00);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r    <= ST_IDLE;
            cls_r      <= 5'h00;
            corr_cnt_r <= 2'h0;
            card_cls_r <= 5'h00;
            first_r    <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_p && lowest != 5'h00)
                    begin
                        cls_r      <= lowest;
                        first_r    <= 1'b1;
                        corr_cnt_r <= 2'h0;
                        state_r    <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (start_p)
                    begin
                        state_r <= ST_IDLE;
                    end
                    else if (atr_p && atr_kind == ATR_NONE)
                    begin
                        corr_cnt_r <= 2'h0;
                        if (next_up != 5'h00)
                        begin
                            cls_r   <= next_up;
                            state_r <= ST_DEACT;
                        end
                        else
                            state_r <= ST_REJECT;
                    end
                    else if (atr_p && atr_kind == ATR_CORRUPT)
                    begin
                        if (corr_cnt_r + 2'h1 < SCS_CORR_MAX)
                        begin
                            corr_cnt_r <= corr_cnt_r + 2'h1;
                            state_r    <= ST_DEACT;
                        end
                        else if (ctrl_r[CTRL_CORR_RETRY] && next_up != 5'h00)
                        begin
                            corr_cnt_r <= 2'h0;
                            cls_r      <= next_up;
                            state_r    <= ST_DEACT;
                        end
                        else
                            state_r <= ST_REJECT;
                    end
                    else if (atr_p)
                    begin
                        corr_cnt_r <= 2'h0;
                        card_cls_r <= atr_cls;
                        first_r    <= 1'b0;
                        if (!consec)
                            state_r <= ST_REJECT;
                        else if ((atr_cls & cls_r) != 5'h00)
                            state_r <= ST_READY;
                        else if (common != 5'h00 && first_r)
                        begin
                            cls_r   <= common_low;
                            state_r <= ST_DEACT;
                        end
                        else
                            state_r <= ST_REJECT;
                    end
                end
                ST_DEACT:
                begin
                    state_r <= ST_ACTIVE;
                end
                ST_ACTIVE:
                begin
                    state_r <= ST_WAIT;
                end
                ST_READY, ST_REJECT:
                begin
                    if (start_p)
                        state_r <= ST_IDLE;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign vcc_class    = cls_r;
    assign vcc_on       = (state_r == ST_WAIT) || (state_r == ST_ACTIVE) || (state_r == ST_READY)
                        || (state_r == ST_REJECT && !ctrl_r[CTRL_DEACT_REJ]);
    assign apdu_allowed = (state_r == ST_READY);

    // ==========================================================
    // Application budget
    // ==========================================================
    logic       app_sel;
    logic       over;
    logic [7:0] budget_r;

    // Status query alone never counts as an application command
    assign app_sel = app_flags_r[0] && (app_flags_r[1] || (app_flags_r[2] && !app_flags_r[3]));
    assign over    = app_flags_r[0] && app_need_r > cap_lim_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            budget_r <= SCS_MIN_BUDGET;
        else if (usb_on_r)
            budget_r <= SCS_USB_BUDGET;
        else if (app_sel && !over && app_need_r != 8'h00)
            budget_r <= app_need_r;
        else
            budget_r <= (cap_lim_r > SCS_MIN_BUDGET) ? cap_lim_r : SCS_MIN_BUDGET;
    end

    // ==========================================================
    // Interrupts and log
    // ==========================================================
    logic [SCS_LOG_AW-1:0] log_wa_r;
    assign ev[EV_ACT]    = state_r == ST_ACTIVE;
    assign ev[EV_READY]  = state_r == ST_WAIT && atr_p && atr_kind == ATR_VALID && consec
                         && (atr_cls & cls_r) != 5'h00;
    logic rej_d_r;
    assign ev[EV_REJECT] = (state_r == ST_REJECT) && !rej_d_r;
    assign ev[EV_DESEL]  = over;
    assign ev[EV_BADSET] = state_r == ST_WAIT && atr_p && atr_kind == ATR_VALID && !consec;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ists_r  <= '0;
            rej_d_r <= 1'b0;
        end
        else
        begin
            rej_d_r <= state_r == ST_REJECT;
            ists_r  <= (ists_r & ~((wr_lo && aw_addr_r == SCS_IRQ_OFF)
                       ? w_data_r[SCS_NEV-1:0] : '0)) | ev;
        end
    end
    assign irq = |(ists_r & imask_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            log_wa_r <= '0;
        else if (atr_p && state_r == ST_WAIT)
            log_wa_r <= log_wa_r + 1'b1;
    end

    scs_log_mem u_log (
        .aclk  (aclk),
        .we    (atr_p && state_r == ST_WAIT),
        .waddr (log_wa_r),
        .wdata ({3'h0, atr_cls, 6'h00, atr_kind}),
        .raddr (log_raddr_r),
        .rdata (log_rdata)
    );

    always_comb
    begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        if (s_axi_araddr == SCS_CTRL_OFF) rd_val = {29'h0, ctrl_r};
        else if (s_axi_araddr == SCS_CAPS_OFF) rd_val = {27'h0, caps_r};
        else if (s_axi_araddr == SCS_ATR_OFF) rd_val = {27'h0, card_cls_r};
        else if (s_axi_araddr == SCS_STAT_OFF)
            rd_val = {16'h0, corr_cnt_r, 6'(state_r), 3'h0, cls_r};
        else if (s_axi_araddr == SCS_IRQ_OFF) rd_val = {27'h0, ists_r};
        else if (s_axi_araddr == SCS_MASK_OFF) rd_val = {27'h0, imask_r};
        else if (s_axi_araddr == SCS_APP_OFF) rd_val = {20'h0, app_flags_r, app_need_r};
        else if (s_axi_araddr == SCS_BUDGET_OFF) rd_val = {16'h0, budget_r, 7'h0, usb_on_r};
        else if (s_axi_araddr == SCS_ATRLOG_OFF) rd_val = {16'h0, log_rdata};
        else rd_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h3;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ### scs_seq_props.sv
// Port checker for the supply class sequencer, bound to its top
module scs_props
    import scs_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [4:0]  vcc_class,
    input wire logic        vcc_on,
    input wire logic        apdu_allowed,
    input wire logic        irq
);
    // ========================================
    // Helpers
    logic [3:0] since_wr_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Cycles since the last write data handshake, saturating
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (s_axi_wvalid && s_axi_wready))
        begin
            since_wr_r <= 4'h0;
        end
        else if (since_wr_r != 4'hf)
        begin
            since_wr_r <= since_wr_r + 4'h1;
        end
    end

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ========================================
    // Assertions
    AST_RESET_QUIET: assert property ($rose(aresetn) |-> !vcc_on && !apdu_allowed && !irq)
        else $error("Outputs active right after reset");
    AST_CLASS_ONEHOT: assert property (vcc_on |-> $onehot(vcc_class))
        else $error("Supply on without a single class");
    AST_CLASS_STABLE: assert property (vcc_on && $past(vcc_on) |-> $stable(vcc_class))
        else $error("Class changed without deactivation");
    AST_APDU_SAFE: assert property (apdu_allowed |-> vcc_on && $onehot(vcc_class))
        else $error("Commands allowed without supplied class");
    AST_APDU_AFTER_ANSWER: assert property ($rose(apdu_allowed) |-> since_wr_r <= 4'h4)
        else $error("Commands allowed without a fresh answer");
    AST_WRITE_RESP: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("Write response missing");
    AST_READ_RESP: assert property (rd_taken |=> s_axi_rvalid)
        else $error("Read response missing");
    AST_DECERR: assert property (rd_taken ##0 (s_axi_araddr > SCS_ATRLOG_OFF) |=> s_axi_rresp == 2'h3)
        else $error("Unmapped read not refused");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read response dropped or changed");
endmodule

bind scs_seq scs_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vcc_class, .vcc_on,
    .apdu_allowed, .irq);

// ### scs_seq_tb.sv
// Self-checking testbench for the supply class sequencer
module scs_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;

    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} scs_exp_t;

    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, vcc_on, apdu_allowed, irq, card_ans;
    logic [1:0]  s_axi_bresp, s_axi_rresp, card_mode;
    logic [3:0]  s_axi_wstrb;
    logic [4:0]  vcc_class, card_flags;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, card_delay;
    logic [31:0] s_axi_wdata, s_axi_rdata, card_word;
    logic [31:0] seed = 32'h14;
    scs_exp_t    rq[$];
    scs_exp_t    got;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    scs_seq DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .vcc_class, .vcc_on, .apdu_allowed, .irq);

    scs_card_model card (.aclk, .vcc_on, .mode(card_mode), .flags(card_flags),
        .delay(card_delay), .answered(card_ans), .word(card_word));

    // ========================================
    // Utilities
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ========================================
    // Bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ga = 1'b0;
        logic gw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (!ga && s_axi_awready)
            begin
                ga = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!gw && s_axi_wready)
            begin
                gw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!(ga && gw));
        repeat (rnd() % 3) @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk iff s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back('{e & m, m, (a > SCS_ATRLOG_OFF) ? 2'h3 : 2'h0});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk iff s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat (rnd() % 3) @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk iff s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // Card answers after a random delay; the bench reports it to the block
    task automatic round(input logic [1:0] md, input logic [4:0] fl);
        card_mode <= md;
        card_flags <= fl;
        card_delay <= 8'(rnd() % 24);
        @(posedge aclk iff card_ans);
        wr(SCS_ATR_OFF, card_word);
        repeat (4) @(posedge aclk);
    endtask

    // From a finished run: back to idle, then start again
    task automatic go(input logic [31:0] c);
        wr(SCS_CTRL_OFF, c);
        wr(SCS_CTRL_OFF, c);
        repeat (4) @(posedge aclk);
    endtask

    // ========================================
    // Clock, monitor, timeout
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (s_axi_rvalid && s_axi_rready)
        begin
            got = rq.pop_front();
            check(s_axi_rdata & got.m, got.d);
            check(32'(s_axi_rresp), 32'(got.r));
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            check(32'(s_axi_bresp), 32'h0);
        end
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    // ========================================
    // Scenarios
    initial
    begin
        aresetn <= 1'b0;
        s_axi_awaddr <= 8'h00;
        s_axi_awvalid <= 1'b0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_araddr <= 8'h00;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        card_mode <= ATR_NONE;
        card_flags <= 5'h00;
        card_delay <= 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(SCS_CAPS_OFF, 32'h7, 32'h1f);
        rd(8'h24, 32'h0, 32'h0);
        rd(SCS_STAT_OFF, 32'h100, 32'h3f1f);
        check(32'(vcc_on), 32'h0);
        // Mute card: C, B, A, then refused
        wr(SCS_CTRL_OFF, 32'h1);
        repeat (4) @(posedge aclk);
        check(32'(vcc_class), 32'h4);
        round(ATR_NONE, 5'h00);
        check(32'(vcc_class), 32'h2);
        round(ATR_NONE, 5'h00);
        check(32'(vcc_class), 32'h1);
        round(ATR_NONE, 5'h00);
        rd(SCS_STAT_OFF, 32'h2000, 32'h3f00);
        // Corrupted answers: two retries in C, then one step up
        go(32'h3);
        for (int i = 1; i < 3; i++)
        begin
            round(ATR_CORRUPT, 5'h00);
            rd(SCS_STAT_OFF, 32'h4 | (32'(i) << 14), 32'hc01f);
        end
        round(ATR_CORRUPT, 5'h00);
        rd(SCS_STAT_OFF, 32'h2, 32'hc01f);
        round(ATR_VALID, 5'h02);
        check(32'(apdu_allowed), 32'h1);
        // Card supports A and B only
        go(32'h1);
        round(ATR_VALID, 5'h03);
        check(32'(vcc_class), 32'h2);
        round(ATR_VALID, 5'h03);
        check(32'(apdu_allowed), 32'h1);
        // No common class, supply dropped on refusal
        go(32'h5);
        round(ATR_VALID, 5'h18);
        check(32'({apdu_allowed, vcc_on}), 32'h0);
        // Gapped class set
        go(32'h1);
        round(ATR_VALID, 5'h05);
        check(32'(apdu_allowed), 32'h0);
        rd(SCS_IRQ_OFF, 32'h14, 32'h14);
        rd(SCS_ATR_OFF, 32'h05, 32'h1f);
        // Interrupt mask and clear
        check(32'(irq), 32'h0);
        wr(SCS_MASK_OFF, 32'h10);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h1);
        wr(SCS_IRQ_OFF, 32'h10);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0);
        rd(SCS_IRQ_OFF, 32'h0, 32'h10);
        // Supply budget
        wr(SCS_BUDGET_OFF, 32'h05);
        rd(SCS_BUDGET_OFF, 32'h0a00, 32'hff00);
        wr(SCS_BUDGET_OFF, 32'h14);
        wr(SCS_APP_OFF, 32'h90f);
        rd(SCS_BUDGET_OFF, 32'h1400, 32'hff00);
        wr(SCS_APP_OFF, 32'h30f);
        rd(SCS_BUDGET_OFF, 32'h0f00, 32'hff00);
        wr(SCS_APP_OFF, 32'h50f);
        rd(SCS_BUDGET_OFF, 32'h0f00, 32'hff00);
        wr(SCS_APP_OFF, 32'h928);
        rd(SCS_IRQ_OFF, 32'h8, 32'h8);
        wr(SCS_BUDGET_OFF, 32'h114);
        rd(SCS_BUDGET_OFF, 32'h3c00, 32'hff00);
        repeat (4) @(posedge aclk);
        close_out();
    end
endmodule
